// *** core/insulation_alarm_relay_drive.sv ***
// Purpose: decides the main alarm and early-warning relay coils of an insulation monitor
// Assumes: measurement arrives on clk; fault pins are asynchronous and are synchronised
// Notes: coil high means energised; loss of auxiliary supply drops both coils
//
// Behaviour
// - Main output failsafe or standard, failsafe default
// - Failsafe main energised without fault or held
// - Failsafe main drops on faults, errors, startup
// - Standard main energised on fault, inhibit, errors
// - Standard main drops otherwise, including startup
// - Early warning failsafe, standard, mirror; failsafe default
// - Failsafe warning energised when healthy or held
// - Failsafe warning drops on faults and errors
// - Standard warning energised on faults or errors
// - Standard warning drops otherwise, including startup
// - Mirror warning follows main while operating
// - Mirror stops following when device inoperative
// - Relay self-test toggles relays three seconds
// - Failed self-test counts as product error
// - System error from disconnect, overvoltage, overcapacitance
// - Mode mapping is default, assignments reassignable
// - Mask bits: 0,4,8,16,24 select conditions
// - Faults clear above 1.2 times threshold
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "relay_drive_consts.svh"

module insulation_alarm_relay_drive
    import relay_drive_pkg::*;
#(
    parameter int unsigned TEST_CYCLES = `TEST_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdata,
    // Measurement from the measuring logic
    input wire logic measValid,
    input wire logic [`MEAS_W-1:0] measValue,
    // Asynchronous condition pins
    input wire logic ackButton,
    input wire logic transientFault,
    input wire logic injectionInhibit,
    input wire logic auxPowerOk,
    input wire logic selfTestFail,
    input wire logic injDisconnected,
    input wire logic overVoltage,
    input wire logic overCapacitance,
    input wire logic deviceInoperative,
    // Relay coils
    output logic mainCoil,
    output logic ewCoil
);

    localparam int NPIN = 9;

    state_t s_q;
    state_t s_d;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinSync;
    logic ackS;
    logic transS;
    logic inhS;
    logic auxS;
    logic testFailS;
    logic discS;
    logic ovS;
    logic ocS;
    logic inopS;
    logic sysErr;
    logic prodErr;
    logic inoperative;
    logic [31:0] cond;
    logic [31:0] mainMapEff;
    logic [31:0] ewMapEff;
    logic mainHit;
    logic ewHit;
    logic mainDecide;
    logic ewDecide;
    logic [`MEAS_W+2:0] measScaled;
    logic [`MEAS_W+2:0] insScaled;
    logic [`MEAS_W+2:0] prevScaled;
    logic wrCtrl;
    logic testStart;

    assign pinRaw = {ackButton, transientFault, injectionInhibit, auxPowerOk, selfTestFail,
                     injDisconnected, overVoltage, overCapacitance, deviceInoperative};

    pin_sync #(
        .WIDTH(NPIN)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(pinRaw),
        .pinOut(pinSync)
    );

    assign {ackS, transS, inhS, auxS, testFailS, discS, ovS, ocS, inopS} = pinSync;

    assign sysErr = discS | ovS | ocS;
    assign prodErr = testFailS | inopS;
    assign inoperative = inopS | ~auxS;

    // hysteresis compare, scaled by 5 and 6
    assign measScaled = (`MEAS_W+3)'(measValue) * (`MEAS_W+3)'(`HYST_DEN);
    assign insScaled = (`MEAS_W+3)'(s_q.insThr) * (`MEAS_W+3)'(`HYST_NUM);
    assign prevScaled = (`MEAS_W+3)'(s_q.prevThr) * (`MEAS_W+3)'(`HYST_NUM);

    // Conditions seen by both masks; a transient fault or a held ack masks the alarms
    always_comb begin
        cond = 32'h00000000;
        cond[`MAP_PREV] = (s_q.prevFault | s_q.insFault) & ~transS & ~s_q.acked;
        cond[`MAP_INS] = s_q.insFault & ~transS & ~s_q.acked;
        cond[`MAP_INHIBIT] = inhS & s_q.inhibitSignal;
        cond[`MAP_SYSERR] = sysErr;
        cond[`MAP_PRODERR] = prodErr;
    end

    // fixed bits: insulation always on main, preventive on warning when enabled
    always_comb begin
        mainMapEff = s_q.mainMap & `MAP_WRITABLE;
        mainMapEff[`MAP_INS] = 1'b1;
        ewMapEff = s_q.ewMap & `MAP_WRITABLE;
        ewMapEff[`MAP_PREV] = (s_q.prevThr != `MEAS_W'(0));
        if (s_q.ewMode == EW_MIRROR) begin
            ewMapEff = 32'h00000000;
        end
    end

    assign mainHit = |(cond & mainMapEff);
    assign ewHit = |(cond & ewMapEff);

    always_comb begin
        if (s_q.mainMode == MAIN_FAILSAFE) begin
            mainDecide = ~mainHit;
        end else begin
            // standard main energised only when alarmed
            mainDecide = mainHit;
        end
        case (s_q.ewMode)
            EW_FAILSAFE: ewDecide = ~ewHit;
            EW_STANDARD: ewDecide = ewHit;
            EW_MIRROR: ewDecide = mainDecide & ~inoperative;
            default: ewDecide = 1'b0;
        endcase
    end

    assign wrCtrl = wrStrobe && (addr == `OFS_CTRL);
    assign testStart = wrCtrl && wdata[`CTRL_TEST_START];

    always_comb begin
        s_d = s_q;

        // Register writes; an undefined warning mode code is ignored
        if (wrCtrl) begin
            s_d.mainMode = main_mode_t'(wdata[`CTRL_MAIN_MODE]);
            if (wdata[`CTRL_EW_HI:`CTRL_EW_LO] != 2'h3) begin
                s_d.ewMode = ew_mode_t'(wdata[`CTRL_EW_HI:`CTRL_EW_LO]);
            end
            s_d.ackHolds = wdata[`CTRL_ACK_HOLD];
            s_d.inhibitSignal = wdata[`CTRL_INH_SIG];
            s_d.testRelays = wdata[`CTRL_TEST_RELAYS];
        end
        if (wrStrobe && addr == `OFS_INS_THR) begin
            s_d.insThr = wdata[`MEAS_W-1:0];
        end
        if (wrStrobe && addr == `OFS_PREV_THR) begin
            s_d.prevThr = wdata[`MEAS_W-1:0];
        end
        if (wrStrobe && addr == `OFS_MAIN_MAP) begin
            s_d.mainMap = wdata & `MAP_WRITABLE;
        end
        if (wrStrobe && addr == `OFS_EW_MAP) begin
            s_d.ewMap = wdata & `MAP_WRITABLE;
        end

        // trip below threshold, clear above 1.2 times
        if (measValid) begin
            if (measValue < s_q.insThr) begin
                s_d.insFault = 1'b1;
            end else if (measScaled > insScaled) begin
                s_d.insFault = 1'b0;
            end
            if (s_q.prevThr == `MEAS_W'(0)) begin
                s_d.prevFault = 1'b0;
            end else if (measValue < s_q.prevThr) begin
                s_d.prevFault = 1'b1;
            end else if (measScaled > prevScaled) begin
                s_d.prevFault = 1'b0;
            end
            s_d.firstMeas = 1'b0;
        end

        // Acknowledge holds only while the fault stands and holding is enabled
        s_d.ackSeen = ackS;
        if (!s_d.insFault || !s_q.ackHolds) begin
            s_d.acked = 1'b0;
        end else if (ackS && !s_q.ackSeen) begin
            s_d.acked = 1'b1;
        end

        case (s_q.testState)
            TEST_IDLE: begin
                if (testStart && s_d.testRelays) begin
                    s_d.testState = TEST_RUN;
                    s_d.testCount = 32'(TEST_CYCLES) - 32'h00000001;
                end
            end
            TEST_RUN: begin
                if (s_q.testCount == 32'h00000000) begin
                    s_d.testState = TEST_IDLE;
                end else begin
                    s_d.testCount = s_q.testCount - 32'h00000001;
                end
            end
            default: s_d.testState = TEST_IDLE;
        endcase

        // supply loss, then startup, override all else
        if (!auxS) begin
            s_d.mainCoil = 1'b0;
            s_d.ewCoil = 1'b0;
        end else if (s_q.firstMeas) begin
            s_d.mainCoil = 1'b0;
            s_d.ewCoil = 1'b0;
        end else if (s_q.testState == TEST_RUN) begin
            s_d.mainCoil = ~mainDecide;
            s_d.ewCoil = ~ewDecide;
        end else begin
            s_d.mainCoil = mainDecide;
            s_d.ewCoil = ewDecide;
        end

        // Read data stands for one cycle after the strobe
        s_d.rdata = 32'h00000000;
        if (rdStrobe) begin
            case (addr)
                `OFS_CTRL: begin
                    s_d.rdata[`CTRL_MAIN_MODE] = s_q.mainMode;
                    s_d.rdata[`CTRL_EW_HI:`CTRL_EW_LO] = s_q.ewMode;
                    s_d.rdata[`CTRL_ACK_HOLD] = s_q.ackHolds;
                    s_d.rdata[`CTRL_INH_SIG] = s_q.inhibitSignal;
                    s_d.rdata[`CTRL_TEST_RELAYS] = s_q.testRelays;
                end
                `OFS_INS_THR: s_d.rdata[`MEAS_W-1:0] = s_q.insThr;
                `OFS_PREV_THR: s_d.rdata[`MEAS_W-1:0] = s_q.prevThr;
                `OFS_MAIN_MAP: s_d.rdata = mainMapEff;
                `OFS_EW_MAP: s_d.rdata = ewMapEff;
                `OFS_STATUS: begin
                    s_d.rdata[`ST_MAIN_COIL] = s_q.mainCoil;
                    s_d.rdata[`ST_EW_COIL] = s_q.ewCoil;
                    s_d.rdata[`ST_FIRST_MEAS] = s_q.firstMeas;
                    s_d.rdata[`ST_TEST_RUN] = (s_q.testState == TEST_RUN);
                    s_d.rdata[`ST_ACKED] = s_q.acked;
                    s_d.rdata[`ST_COND_LO + 4:`ST_COND_LO] = {cond[`MAP_PRODERR],
                        cond[`MAP_SYSERR], cond[`MAP_INHIBIT], cond[`MAP_INS],
                        cond[`MAP_PREV]};
                end
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q.mainMode <= MAIN_FAILSAFE;
            s_q.ewMode <= EW_FAILSAFE;
            s_q.ackHolds <= 1'b0;
            s_q.inhibitSignal <= 1'b0;
            s_q.testRelays <= 1'b0;
            s_q.insThr <= `RST_INS_THR;
            s_q.prevThr <= `RST_PREV_THR;
            s_q.mainMap <= `RST_MAIN_MAP;
            s_q.ewMap <= `RST_EW_MAP;
            s_q.insFault <= 1'b0;
            s_q.prevFault <= 1'b0;
            s_q.acked <= 1'b0;
            s_q.ackSeen <= 1'b0;
            s_q.firstMeas <= 1'b1;
            s_q.testState <= TEST_IDLE;
            s_q.testCount <= 32'h00000000;
            s_q.mainCoil <= 1'b0;
            s_q.ewCoil <= 1'b0;
            s_q.rdata <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign mainCoil = s_q.mainCoil;
    assign ewCoil = s_q.ewCoil;
    assign rdata = s_q.rdata;

endmodule

// *** core/pin_sync.sv ***
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: pins change slowly compared with clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);

    logic [WIDTH-1:0] stage1_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    stage1_q[i] <= 1'b0;
                    pinOut[i] <= 1'b0;
                end else begin
                    stage1_q[i] <= pinIn[i];
                    pinOut[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

endmodule

// *** include/relay_drive_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the relay drive
// Assumes: byte addresses on an 8-bit register address, 32-bit data
// Notes: definitions only
`ifndef RELAY_DRIVE_CONSTS_SVH
`define RELAY_DRIVE_CONSTS_SVH

// Register offsets
`define OFS_CTRL 8'h00
`define OFS_INS_THR 8'h04
`define OFS_PREV_THR 8'h08
`define OFS_MAIN_MAP 8'h0C
`define OFS_EW_MAP 8'h10
`define OFS_STATUS 8'h14

// Control fields
`define CTRL_MAIN_MODE 0
`define CTRL_EW_LO 1
`define CTRL_EW_HI 2
`define CTRL_ACK_HOLD 4
`define CTRL_INH_SIG 5
`define CTRL_TEST_RELAYS 6
`define CTRL_TEST_START 8

// Condition bit positions, shared by both assignment masks
`define MAP_PREV 0
`define MAP_INS 4
`define MAP_INHIBIT 8
`define MAP_SYSERR 16
`define MAP_PRODERR 24
`define MAP_WRITABLE 32'h01010111

// Status fields
`define ST_MAIN_COIL 0
`define ST_EW_COIL 1
`define ST_FIRST_MEAS 2
`define ST_TEST_RUN 3
`define ST_ACKED 4
`define ST_COND_LO 8

// Reset values
`define RST_INS_THR 16'h0001
`define RST_PREV_THR 16'h0000
`define RST_MAIN_MAP 32'h01010110
`define RST_EW_MAP 32'h01010000

// Measurement width
`define MEAS_W 16

// Hysteresis 1.2 as 6/5
`define HYST_NUM 6
`define HYST_DEN 5

// Relay self-test toggle time
`define TEST_TIME_MS 3000
`define CLK_HZ 50000000
`define TEST_CYCLES (`TEST_TIME_MS * (`CLK_HZ / 1000))

`endif

// *** include/relay_drive_pkg.sv ***
// Purpose: types of the relay drive
// Assumes: relay_drive_consts.svh supplies the widths
// Notes: state is one packed struct
`include "relay_drive_consts.svh"

package relay_drive_pkg;

    typedef enum logic [0:0] {MAIN_FAILSAFE, MAIN_STANDARD} main_mode_t;

    typedef enum logic [1:0] {EW_FAILSAFE, EW_STANDARD, EW_MIRROR} ew_mode_t;

    typedef enum logic [0:0] {TEST_IDLE, TEST_RUN} test_state_t;

    typedef struct packed {
        main_mode_t mainMode;
        ew_mode_t ewMode;
        logic ackHolds;
        logic inhibitSignal;
        logic testRelays;
        logic [`MEAS_W-1:0] insThr;
        logic [`MEAS_W-1:0] prevThr;
        logic [31:0] mainMap;
        logic [31:0] ewMap;
        logic insFault;
        logic prevFault;
        logic acked;
        logic ackSeen;
        logic firstMeas;
        test_state_t testState;
        logic [31:0] testCount;
        logic mainCoil;
        logic ewCoil;
        logic [31:0] rdata;
    } state_t;

endpackage

// *** test/insulation_alarm_relay_drive_tb.sv ***
// Purpose: self-checking bench of the relay drive
// Assumes: short self-test count, thresholds 100 and 200
// Notes: random pins, modes and masks with fixed corner cases
`timescale 1ns/1ps
`include "relay_drive_consts.svh"
module insulation_alarm_relay_drive_tb;
    localparam int unsigned TEST_CYCLES = 20;
    logic clk, rst_b, wrStrobe, rdStrobe, measValid, ackButton, transientFault;
    logic injectionInhibit, auxPowerOk, selfTestFail, injDisconnected, overVoltage;
    logic overCapacitance, deviceInoperative, mainCoil, ewCoil, mainClosed, ewClosed;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, mainMask, ewMask, rv, r;
    logic [15:0] measValue;
    logic mainStd, ackHold, inhSig, insF, prevF, acked;
    logic [1:0] ewMode, ex;
    logic [7:0] ra [6] = '{`OFS_CTRL, `OFS_INS_THR, `OFS_PREV_THR, `OFS_MAIN_MAP, `OFS_EW_MAP,
        8'h20};
    logic [31:0] rx [6] = '{32'h0, 32'h1, 32'h0, `RST_MAIN_MAP, `RST_EW_MAP, 32'h0};
    int n_errors = 0, n_tests = 0, seed = 40, i;

    insulation_alarm_relay_drive #(.TEST_CYCLES(TEST_CYCLES)) uut (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdata(rdata), .measValid(measValid), .measValue(measValue),
        .ackButton(ackButton), .transientFault(transientFault),
        .injectionInhibit(injectionInhibit), .auxPowerOk(auxPowerOk),
        .selfTestFail(selfTestFail), .injDisconnected(injDisconnected),
        .overVoltage(overVoltage), .overCapacitance(overCapacitance),
        .deviceInoperative(deviceInoperative), .mainCoil(mainCoil), .ewCoil(ewCoil));
    relay_contacts plc (.mainCoil(mainCoil), .ewCoil(ewCoil), .mainClosed(mainClosed),
        .ewClosed(ewClosed));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic set_ctrl(input logic [31:0] extra);
        wr(`OFS_CTRL, {26'h0, inhSig, ackHold, 1'b0, ewMode, mainStd} | extra);
    endtask
    task automatic measure(input logic [15:0] v);
        @(posedge clk);
        measValue <= v;
        measValid <= 1'b1;
        @(posedge clk);
        measValid <= 1'b0;
        // trip below threshold, clear above 1.2 times
        if (v < 16'h0064) insF = 1'b1;
        else if (32'(v) * 5 > 32'h0258) insF = 1'b0;
        if (v < 16'h00C8) prevF = 1'b1;
        else if (32'(v) * 5 > 32'h04B0) prevF = 1'b0;
        acked = acked & insF;
    endtask
    task automatic check_coils(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t coils %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Coil pair {warning, main} from the bench's own fault view
    function automatic logic [1:0] expc();
        logic [31:0] c;
        logic mainHit, ewHit, mainD;
        c = 32'h0;
        c[`MAP_PREV] = (prevF | insF) & ~transientFault & ~acked;
        c[`MAP_INS] = insF & ~transientFault & ~acked;
        c[`MAP_INHIBIT] = injectionInhibit & inhSig;
        c[`MAP_SYSERR] = injDisconnected | overVoltage | overCapacitance;
        c[`MAP_PRODERR] = selfTestFail | deviceInoperative;
        mainHit = |(c & (mainMask | 32'h00000010));
        ewHit = |(c & (ewMask | 32'h00000001));
        mainD = mainStd ? mainHit : ~mainHit;
        if (!auxPowerOk) return 2'b00;
        if (ewMode == 2'h0) return {~ewHit, mainD};
        if (ewMode == 2'h1) return {ewHit, mainD};
        return {mainD & ~deviceInoperative, mainD};
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        {wrStrobe, rdStrobe, measValid, ackButton, transientFault, injectionInhibit} = 6'h00;
        {selfTestFail, injDisconnected, overVoltage, overCapacitance, deviceInoperative} = 5'h00;
        {mainStd, ackHold, inhSig, insF, prevF, acked} = 6'h00;
        auxPowerOk = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        measValue = 16'h0000;
        ewMode = 2'h0;
        mainMask = `RST_MAIN_MAP;
        ewMask = `RST_EW_MAP;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(ra[i], rv);
            check_reg(rv, rx[i]);
        end
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, rv);
        check_reg(rv, 32'h0);
        wr(`OFS_CTRL, 32'h00000007);
        rd(`OFS_CTRL, rv);
        check_reg(rv, 32'h00000001);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_INS_THR, 32'h00000064);
        rd(`OFS_INS_THR, rv);
        check_reg(rv, 32'h00000064);
        wr(`OFS_PREV_THR, 32'h000000C8);
        repeat (4) @(posedge clk);
        check_coils({ewClosed, mainClosed}, 2'b00);
        rd(`OFS_STATUS, rv);
        check_reg(rv & 32'h0000001F, 32'h00000004);
        $display("registers and startup done");
        measure(16'h00FF);
        for (i = 0; i < 200; i++) begin
            r = $random(seed);
            mainStd = r[0];
            ewMode = (r[2:1] == 2'h3) ? 2'h0 : r[2:1];
            inhSig = r[3];
            if (i >= 100) begin
                mainMask = $random(seed) & `MAP_WRITABLE;
                ewMask = $random(seed) & `MAP_WRITABLE;
            end
            set_ctrl(32'h0);
            wr(`OFS_MAIN_MAP, mainMask);
            if (ewMode != 2'h2) wr(`OFS_EW_MAP, ewMask);
            @(posedge clk);
            transientFault <= r[4];
            injectionInhibit <= r[5];
            injDisconnected <= r[9:6] == 4'h1;
            overVoltage <= r[9:6] == 4'h2;
            overCapacitance <= r[9:6] == 4'h3;
            selfTestFail <= r[12:10] == 3'h0;
            deviceInoperative <= r[15:13] == 3'h0;
            auxPowerOk <= r[18:16] != 3'h0;
            measure({8'h00, r[26:19]});
            repeat (5) @(posedge clk);
            check_coils({ewClosed, mainClosed}, expc());
            rd(`OFS_STATUS, rv);
            check_coils(rv[1:0], expc());
        end
        $display("random conditions done");
        @(posedge clk);
        {transientFault, injectionInhibit, selfTestFail, injDisconnected} <= 4'h0;
        {overVoltage, overCapacitance, deviceInoperative} <= 3'h0;
        auxPowerOk <= 1'b1;
        {mainStd, ewMode, ackHold, inhSig} = 5'b00010;
        mainMask = `RST_MAIN_MAP;
        ewMask = `RST_EW_MAP;
        set_ctrl(32'h0);
        wr(`OFS_MAIN_MAP, mainMask);
        wr(`OFS_EW_MAP, ewMask);
        measure(16'h0032);
        repeat (5) @(posedge clk);
        check_coils({ewClosed, mainClosed}, 2'b00);
        ackButton <= 1'b1;
        repeat (4) @(posedge clk);
        ackButton <= 1'b0;
        acked = 1'b1;
        repeat (5) @(posedge clk);
        check_coils({ewClosed, mainClosed}, 2'b11);
        mainStd = 1'b1;
        set_ctrl(32'h0);
        repeat (3) @(posedge clk);
        check_coils({ewClosed, mainClosed}, 2'b10);
        ackHold = 1'b0;
        acked = 1'b0;
        set_ctrl(32'h0);
        repeat (3) @(posedge clk);
        check_coils({ewClosed, mainClosed}, 2'b01);
        $display("acknowledge done");
        measure(16'h00FF);
        repeat (5) @(posedge clk);
        ex = expc();
        set_ctrl(32'h00000140);
        repeat (3) @(posedge clk);
        check_coils({ewClosed, mainClosed}, ~ex);
        rd(`OFS_STATUS, rv);
        check_reg(rv & 32'h0000001F, 32'h00000009);
        repeat (13) @(posedge clk);
        check_coils({ewClosed, mainClosed}, ~ex);
        repeat (10) @(posedge clk);
        check_coils({ewClosed, mainClosed}, ex);
        $display("relay self-test done");
        complete_run();
    end
endmodule

bind insulation_alarm_relay_drive relay_drive_monitor #(.TEST_CYCLES(TEST_CYCLES)) mon (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdata(rdata), .measValid(measValid), .measValue(measValue),
    .ackButton(ackButton), .transientFault(transientFault),
    .injectionInhibit(injectionInhibit), .auxPowerOk(auxPowerOk),
    .selfTestFail(selfTestFail), .injDisconnected(injDisconnected),
    .overVoltage(overVoltage), .overCapacitance(overCapacitance),
    .deviceInoperative(deviceInoperative), .mainCoil(mainCoil), .ewCoil(ewCoil));

// *** test/relay_contacts.sv ***
// Purpose: relay contacts as seen by an outside controller input
// Assumes: normally open contacts, closed while the coil is energised
// Notes: no timing of contact bounce is modelled
`timescale 1ns/1ps
module relay_contacts (
    // Coils from the drive
    input wire logic mainCoil,
    input wire logic ewCoil,
    // Controller inputs
    output logic mainClosed,
    output logic ewClosed
);
    assign mainClosed = mainCoil;
    assign ewClosed = ewCoil;
endmodule

// *** test/relay_drive_monitor.sv ***
// Purpose: port checker of the relay drive
// Assumes: sees only the top-level ports
// Notes: helpers track warning mode and pin history
`timescale 1ns/1ps
`include "relay_drive_consts.svh"
module relay_drive_monitor #(
    parameter int unsigned TEST_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [31:0] rdata,
    // Measurement and pins
    input wire logic measValid,
    input wire logic [`MEAS_W-1:0] measValue,
    input wire logic ackButton,
    input wire logic transientFault,
    input wire logic injectionInhibit,
    input wire logic auxPowerOk,
    input wire logic selfTestFail,
    input wire logic injDisconnected,
    input wire logic overVoltage,
    input wire logic overCapacitance,
    input wire logic deviceInoperative,
    // Coils
    input wire logic mainCoil,
    input wire logic ewCoil
);
    logic measSeen_q;
    logic mirror_q;
    logic [2:0] okCnt_q;
    logic [2:0] inopCnt_q;
    // Saturating counts cover the two-flop pin delay
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            measSeen_q <= 1'b0;
            mirror_q <= 1'b0;
            okCnt_q <= 3'h0;
            inopCnt_q <= 3'h0;
        end else begin
            measSeen_q <= measSeen_q | measValid;
            if (wrStrobe && addr == `OFS_CTRL && wdata[2:1] != 2'h3) begin
                mirror_q <= wdata[2:1] == 2'h2;
            end
            okCnt_q <= (auxPowerOk && !deviceInoperative) ?
                okCnt_q + {2'h0, okCnt_q != 3'h7} : 3'h0;
            inopCnt_q <= deviceInoperative ? inopCnt_q + {2'h0, inopCnt_q != 3'h7} : 3'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_supply_drop: assert property (!auxPowerOk [*6] |-> !mainCoil && !ewCoil)
        else $error("coil energised without supply");
    a_first_meas: assert property (!measSeen_q |-> !mainCoil && !ewCoil)
        else $error("coil energised before first measurement");
    a_read_pulse: assert property (rdata != 32'h0 |-> $past(rdStrobe))
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (rdStrobe && addr > `OFS_STATUS |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_mask_bits: assert property (rdStrobe && (addr == `OFS_MAIN_MAP || addr == `OFS_EW_MAP)
        |=> (rdata & ~`MAP_WRITABLE) == 32'h0) else $error("mask shows reserved bit");
    a_main_ins: assert property (rdStrobe && addr == `OFS_MAIN_MAP |=> rdata[`MAP_INS])
        else $error("main mask lost insulation bit");
    a_thr_write: assert property (wrStrobe && addr == `OFS_INS_THR ##1 !wrStrobe
        ##1 rdStrobe && addr == `OFS_INS_THR |=> rdata == {16'h0000, $past(wdata[15:0], 3)})
        else $error("threshold readback wrong");
    a_status_coils: assert property (rdStrobe && addr == `OFS_STATUS
        |=> rdata[1:0] == $past({ewCoil, mainCoil})) else $error("status coils differ");
    a_mirror_follow: assert property (mirror_q && $past(mirror_q) && $past(mirror_q, 2)
        && okCnt_q == 3'h7 |-> ewCoil == mainCoil) else $error("mirror not following");
    a_mirror_break: assert property (mirror_q && $past(mirror_q, 2) && inopCnt_q == 3'h7
        |-> !ewCoil) else $error("mirror kept while inoperative");
    c_mirror: cover property (mirror_q && okCnt_q == 3'h7 && mainCoil);
    c_inop: cover property (mirror_q && inopCnt_q == 3'h7);
    c_test: cover property (wrStrobe && addr == `OFS_CTRL && wdata[`CTRL_TEST_START]);
endmodule
